// ### asfc_map.vh
`ifndef ASFC_MAP_VH
`define ASFC_MAP_VH

// =====================================================================
// frame layout
`define ASFC_FRAME_W      24
`define ASFC_FIELD_W      18
`define ASFC_TAIL_ZERO    4'h0
`define ASFC_STAT_BITS    2'h0
`define ASFC_LAST_FALL    5'd23
`define ASFC_CNT_ONE      5'd1

// =====================================================================
// result coding
`define ASFC_POS_FS       65536
`define ASFC_NEG_FS       -65536
`define ASFC_CODE_OVER    18'h30000
`define ASFC_CODE_UNDER   18'h0ffff
`define ASFC_RES_MSB      16

// =====================================================================
// input word layout
`define ASFC_WORD_W       16
`define ASFC_WORD_DONE    5'd16
`define ASFC_PRE_HI       15
`define ASFC_PRE_LO       13
`define ASFC_PRE_LOAD     3'h5
`define ASFC_POS_SGL      12
`define ASFC_POS_SWAP     11
`define ASFC_ADDR_HI      10
`define ASFC_ADDR_LO      8
`define ASFC_POS_EN2      7
`define ASFC_POS_IM       6
`define ASFC_POS_FA       5
`define ASFC_POS_FB       4
`define ASFC_POS_SPD      3
`define ASFC_GAIN_HI      2
`define ASFC_GAIN_LO      0

// =====================================================================
// power-up configuration
`define ASFC_RST_CHAN_POS 4'h0
`define ASFC_RST_CHAN_NEG 4'h1
`define ASFC_RST_REJ_A    1'b0
`define ASFC_RST_REJ_B    1'b0
`define ASFC_RST_GAIN     3'h0

`endif

// ### asfc_buf2.v
`timescale 1ns/1ps

// =====================================================================
// two-entry result buffer
module asfc_buf2 #(
    parameter W = 18
) (
    // clock and reset
    input  wire         clk_sys,
    input  wire         rst,
    input  wire         clk_en,
    // fill side
    input  wire [W-1:0] in_data,
    input  wire         in_valid,
    output wire         in_ready,
    // drain side
    output wire [W-1:0] out_data,
    output wire         out_valid,
    input  wire         out_ready
);

    reg [W-1:0] ent0_reg;
    reg [W-1:0] ent1_reg;
    reg [1:0]   cnt_reg;
    wire        push;
    wire        pop;

    assign in_ready  = ~cnt_reg[1];
    assign out_valid = |cnt_reg;
    assign out_data  = ent0_reg;
    assign push      = in_valid & ~cnt_reg[1];
    assign pop       = out_ready & (|cnt_reg);

    always @(posedge clk_sys) begin
        if (rst) begin
            ent0_reg <= {W{1'b0}};
            ent1_reg <= {W{1'b0}};
            cnt_reg  <= 2'h0;
        end else if (clk_en) begin
            if (push && pop) begin
                if (cnt_reg == 2'h1) begin
                    ent0_reg <= in_data;
                end else begin
                    ent0_reg <= ent1_reg;
                    ent1_reg <= in_data;
                end
            end else if (push) begin
                if (cnt_reg == 2'h0) begin
                    ent0_reg <= in_data;
                end else begin
                    ent1_reg <= in_data;
                end
                cnt_reg <= cnt_reg + 2'h1;
            end else if (pop) begin
                ent0_reg <= ent1_reg;
                cnt_reg  <= cnt_reg - 2'h1;
            end
        end
    end

endmodule

// ### asfc_top.v
`timescale 1ns/1ps
`include "asfc_map.vh"

// How it works
// [RULE1] signed 17-bit result occupies frame bits 20..4, msb first
// [RULE2] frame bits 3..0 always low
// [RULE3] chip select high: output released, serial clock ignored
// [RULE4] chip select low: output shows done flag, falls when result ready; after the 24th fall the code holds it high until select rises
// [RULE5] host samples bit 23 on first rise; bit 22 leaves on first fall
// [RULE6] bit 0 leaves on 23rd fall; host latches it on 24th rise
// [RULE7] 24th fall drives output high, starting the next conversion
// [RULE8] overrange clamps to +fs, underrange to -fs minus one
// [RULE9] sign and msb code over, under and in-range inputs
// [RULE10] doubled rate may toggle the sign on a zero result
// [RULE11] input word is 16 bits: channel group then configuration group
// [RULE12] reset loads default channel and configuration, starts a conversion
// [RULE13] host writes a new word only during data output
// [RULE14] host begins each word with 000, 100 or 101
// [RULE15] patterns 000 and 100 keep previous channel and configuration
// [RULE16] after 101, five channel bits; first picks differential or single-ended
// [RULE17] swap bit and three address bits choose channels and polarity
// [RULE18] configuration load flag low keeps previous configuration
// [RULE19] temperature pick bit selects the internal sensor
// [RULE20] two rejection bits follow the temperature pick
// [RULE21] speed bit picks normal rate with calibration or doubled rate
// [RULE22] order: temp pick, two rejection bits, speed, three gain bits
// [RULE23] address picks pair 2n/2n+1, swap reverses; single-ended uses shared return
module asfc_top #(
    parameter VW = 20
) (
    // clock, reset, enable
    input  wire          clk_sys,
    input  wire          rst,
    input  wire          clk_en,
    // serial link
    input  wire          cs_n,
    input  wire          sck,
    input  wire          serial_in,
    output wire          serial_out,
    output wire          serial_out_oe,
    // conversion engine
    input  wire [VW-1:0] conv_value,
    input  wire          conv_valid,
    output wire          conv_ready,
    output wire          conv_start,
    // active configuration
    output wire          single_ended_sel,
    output wire [3:0]    chan_pos,
    output wire [3:0]    chan_neg,
    output wire          neg_is_common,
    output wire          temp_sensor_pick,
    output wire          reject_sel_a,
    output wire          reject_sel_b,
    output wire          rate_double_sel,
    output wire [2:0]    gain_code
);

    localparam [3:0] ST_IDLE  = 4'h1;
    localparam [3:0] ST_WAIT  = 4'h2;
    localparam [3:0] ST_SHIFT = 4'h4;
    localparam [3:0] ST_DONE  = 4'h8;

    // =================================================================
    // pin synchronisers: [2] chip select, [1] serial clock, [0] data
    reg  [2:0] sync1_reg;
    reg  [2:0] sync2_reg;
    reg  [2:0] sync3_reg;
    reg  [2:0] filt_reg;
    wire [2:0] agree;
    wire [2:0] filt_next;
    wire [2:0] rise;
    wire [2:0] fall;

    assign agree     = sync2_reg ~^ sync3_reg;
    assign filt_next = (agree & sync3_reg) | (~agree & filt_reg);
    assign rise      = filt_next & ~filt_reg;
    assign fall      = ~filt_next & filt_reg;

    always @(posedge clk_sys) begin
        if (rst) begin
            // idle levels: deselected, serial clock low, data low
            sync1_reg <= 3'h4;
            sync2_reg <= 3'h4;
            sync3_reg <= 3'h4;
            filt_reg  <= 3'h4;
        end else if (clk_en) begin
            sync1_reg <= {cs_n, sck, serial_in};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            filt_reg  <= filt_next;
        end
    end

    // =================================================================
    // result coding and buffer
    reg                         rate_double_reg;
    reg                         zero_sign_reg;
    reg  [`ASFC_FIELD_W-1:0]    code_next;
    wire                        buf_in_ready;
    wire [`ASFC_FIELD_W-1:0]    buf_data;
    wire                        buf_valid;
    reg                         pop_reg;
    wire                        zero_in;

    assign zero_in = (conv_value == {VW{1'b0}});

    always @* begin
        if ($signed(conv_value) >= `ASFC_POS_FS) begin
            code_next = `ASFC_CODE_OVER; // RULE8 RULE9
        end else if ($signed(conv_value) < `ASFC_NEG_FS) begin
            code_next = `ASFC_CODE_UNDER; // RULE8 RULE9
        end else begin
            // in range: sign is the inverted result msb
            code_next = {~conv_value[`ASFC_RES_MSB],
                         conv_value[`ASFC_RES_MSB:0]}; // RULE9
            if (rate_double_reg && zero_in) begin
                code_next[`ASFC_FIELD_W-1] = zero_sign_reg; // RULE10
            end
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            zero_sign_reg <= 1'b1;
        end else if (clk_en) begin
            if (conv_valid && buf_in_ready && zero_in && rate_double_reg) begin
                zero_sign_reg <= ~zero_sign_reg; // RULE10
            end
        end
    end

    asfc_buf2 #(
        .W (`ASFC_FIELD_W)
    ) u_buf (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .clk_en    (clk_en),
        .in_data   (code_next),
        .in_valid  (conv_valid),
        .in_ready  (buf_in_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (pop_reg)
    );

    assign conv_ready = buf_in_ready;

    // =================================================================
    // frame engine
    reg [3:0]                 state_reg;
    reg [`ASFC_FRAME_W-1:0]   frame_reg;
    reg [4:0]                 rise_cnt_reg;
    reg [4:0]                 fall_cnt_reg;
    reg [`ASFC_WORD_W-1:0]    rx_reg;
    reg                       out_reg;
    reg                       oe_reg;
    reg                       start_reg;
    reg                       finish;
    reg                       sgl_reg;
    reg [3:0]                 pos_reg;
    reg [3:0]                 neg_reg;
    reg                       com_reg;
    reg                       temp_reg;
    reg                       rej_a_reg;
    reg                       rej_b_reg;
    reg [2:0]                 gain_reg;
    wire                      word_ok;
    wire                      swap;
    wire [2:0]                addr;

    assign word_ok = (rise_cnt_reg >= `ASFC_WORD_DONE) &&
                     (rx_reg[`ASFC_PRE_HI:`ASFC_PRE_LO] == `ASFC_PRE_LOAD); // RULE11 RULE15
    assign swap    = rx_reg[`ASFC_POS_SWAP];
    assign addr    = rx_reg[`ASFC_ADDR_HI:`ASFC_ADDR_LO];

    // frame ends on the 24th fall or on an abort by chip select
    always @* begin
        finish = 1'b0;
        if (state_reg == ST_SHIFT) begin
            if (rise[2]) begin
                finish = 1'b1;
            end else if (fall[1] && fall_cnt_reg == `ASFC_LAST_FALL) begin
                finish = 1'b1;
            end
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            state_reg       <= ST_IDLE;
            frame_reg       <= {`ASFC_FRAME_W{1'b0}};
            rise_cnt_reg    <= 5'h0;
            fall_cnt_reg    <= 5'h0;
            rx_reg          <= {`ASFC_WORD_W{1'b0}};
            out_reg         <= 1'b0;
            oe_reg          <= 1'b0;
            pop_reg         <= 1'b0;
            start_reg       <= 1'b1; // RULE12
            sgl_reg         <= 1'b0; // RULE12
            pos_reg         <= `ASFC_RST_CHAN_POS;
            neg_reg         <= `ASFC_RST_CHAN_NEG;
            com_reg         <= 1'b0;
            temp_reg        <= 1'b0;
            rej_a_reg       <= `ASFC_RST_REJ_A;
            rej_b_reg       <= `ASFC_RST_REJ_B;
            rate_double_reg <= 1'b0;
            gain_reg        <= `ASFC_RST_GAIN;
        end else if (clk_en) begin
            pop_reg   <= 1'b0;
            start_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    oe_reg <= 1'b0; // RULE3
                    if (fall[2]) begin
                        oe_reg       <= 1'b1;
                        out_reg      <= ~buf_valid; // RULE4
                        rise_cnt_reg <= 5'h0;
                        fall_cnt_reg <= 5'h0;
                        state_reg    <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    out_reg <= ~buf_valid; // RULE4
                    if (rise[2]) begin
                        oe_reg    <= 1'b0; // RULE3
                        state_reg <= ST_IDLE;
                    end else if (rise[1] && buf_valid) begin
                        // first rise: host takes the done flag
                        frame_reg    <= {`ASFC_STAT_BITS, buf_data,
                                         `ASFC_TAIL_ZERO}; // RULE1 RULE2 RULE5
                        rx_reg       <= {rx_reg[`ASFC_WORD_W-2:0], filt_next[0]};
                        rise_cnt_reg <= `ASFC_CNT_ONE;
                        state_reg    <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (rise[1]) begin
                        if (rise_cnt_reg < `ASFC_WORD_DONE) begin
                            rx_reg <= {rx_reg[`ASFC_WORD_W-2:0], filt_next[0]}; // RULE11
                        end
                        rise_cnt_reg <= rise_cnt_reg + 5'h1;
                    end
                    if (rise[2]) begin
                        oe_reg    <= 1'b0; // RULE3
                        state_reg <= ST_IDLE;
                    end else if (fall[1]) begin
                        fall_cnt_reg <= fall_cnt_reg + 5'h1;
                        if (fall_cnt_reg == `ASFC_LAST_FALL) begin
                            out_reg   <= 1'b1; // RULE7
                            state_reg <= ST_DONE;
                        end else begin
                            out_reg   <= frame_reg[`ASFC_FRAME_W-2]; // RULE5 RULE6
                            frame_reg <= {frame_reg[`ASFC_FRAME_W-2:0], 1'b0};
                        end
                    end
                end
                ST_DONE: begin
                    out_reg <= 1'b1; // RULE7
                    if (rise[2]) begin
                        oe_reg    <= 1'b0; // RULE3
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    oe_reg    <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            endcase

            // frame end: release result, start conversion, load word
            if (finish) begin
                pop_reg   <= 1'b1;
                start_reg <= 1'b1; // RULE7
                if (word_ok) begin // RULE15
                    sgl_reg <= rx_reg[`ASFC_POS_SGL]; // RULE16
                    pos_reg <= {addr, swap}; // RULE17 RULE23
                    if (rx_reg[`ASFC_POS_SGL]) begin
                        neg_reg <= 4'h0; // RULE23
                        com_reg <= 1'b1; // RULE16
                    end else begin
                        neg_reg <= {addr, ~swap}; // RULE23
                        com_reg <= 1'b0;
                    end
                    if (rx_reg[`ASFC_POS_EN2]) begin // RULE18
                        temp_reg        <= rx_reg[`ASFC_POS_IM]; // RULE19 RULE22
                        rej_a_reg       <= rx_reg[`ASFC_POS_FA]; // RULE20
                        rej_b_reg       <= rx_reg[`ASFC_POS_FB]; // RULE20
                        rate_double_reg <= rx_reg[`ASFC_POS_SPD]; // RULE21
                        gain_reg        <= rx_reg[`ASFC_GAIN_HI:`ASFC_GAIN_LO]; // RULE22
                    end
                end
            end
        end
    end

    // =================================================================
    // outputs
    assign serial_out       = out_reg;
    assign serial_out_oe    = oe_reg;
    assign conv_start       = start_reg;
    assign single_ended_sel = sgl_reg;
    assign chan_pos         = pos_reg;
    assign chan_neg         = neg_reg;
    assign neg_is_common    = com_reg;
    assign temp_sensor_pick = temp_reg;
    assign reject_sel_a     = rej_a_reg;
    assign reject_sel_b     = rej_b_reg;
    assign rate_double_sel  = rate_double_reg;
    assign gain_code        = gain_reg;

endmodule

// ### asfc_asserts.sv
`timescale 1ns/1ps
// =====================================================================
// port checker
module asfc_asserts (
    // clock and reset
    input wire       clk_sys,
    input wire       rst,
    // link and engine
    input wire       cs_n,
    input wire       conv_valid,
    input wire       conv_ready,
    input wire       conv_start,
    input wire       serial_out,
    input wire       serial_out_oe,
    // configuration
    input wire       single_ended_sel,
    input wire [3:0] chan_pos,
    input wire [3:0] chan_neg,
    input wire       neg_is_common,
    input wire       temp_sensor_pick,
    input wire       rate_double_sel,
    input wire [2:0] gain_code
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    reg  [3:0]  hi_cnt_reg;
    wire [14:0] cfg;
    assign cfg = {single_ended_sel, chan_pos, chan_neg, neg_is_common,
                  temp_sensor_pick, rate_double_sel, gain_code};
    // cycles with select high
    always @(posedge clk_sys) begin
        if (rst || !cs_n)
            hi_cnt_reg <= 4'h0;
        else if (hi_cnt_reg != 4'hf)
            hi_cnt_reg <= hi_cnt_reg + 4'h1;
    end
    idle_release_a: assert property (hi_cnt_reg == 4'hf |-> !serial_out_oe && !conv_start)
        else $error("link active while deselected");
    oe_after_sel_a: assert property ($rose(serial_out_oe) |-> !$past(cs_n, 2))
        else $error("output enabled without select");
    start_pulse_a: assert property (conv_start |=> !conv_start)
        else $error("start longer than one cycle");
    ready_fall_a: assert property ($fell(conv_ready) |-> $past(conv_valid) || $past(conv_valid, 2))
        else $error("ready fell without a result");
    cfg_at_start_a: assert property (!$stable(cfg) |-> conv_start)
        else $error("configuration changed outside frame end");
    single_neg_a: assert property (single_ended_sel |-> neg_is_common && chan_neg == 4'h0)
        else $error("single-ended negative not shared return");
    diff_pair_a: assert property (!single_ended_sel |-> !neg_is_common && (chan_pos ^ chan_neg) == 4'h1)
        else $error("differential pair not adjacent");
    rst_dflt_a: assert property ($fell(rst) |-> conv_start && !serial_out_oe && cfg == 15'h0040)
        else $error("reset defaults wrong");
    tail_high_a: assert property (conv_start && serial_out_oe && !cs_n |-> serial_out)
        else $error("output not high at frame end");
    cover property (conv_start && serial_out_oe);
    cover property (!conv_ready);
    cover property (single_ended_sel && temp_sensor_pick);
endmodule

bind asfc_top asfc_asserts u_chk (
    .clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .conv_valid(conv_valid),
    .conv_ready(conv_ready), .conv_start(conv_start), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .single_ended_sel(single_ended_sel),
    .chan_pos(chan_pos), .chan_neg(chan_neg), .neg_is_common(neg_is_common),
    .temp_sensor_pick(temp_sensor_pick), .rate_double_sel(rate_double_sel),
    .gain_code(gain_code)
);

// ### asfc_host.sv
`timescale 1ns/1ps
// =====================================================================
// serial master model
module asfc_host (
    // pacing clock
    input  wire clk_sys,
    // link pins
    output reg  cs_n,
    output reg  sck,
    output reg  serial_in,
    input  wire serial_out
);
    integer i;
    integer w;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        serial_in = 1'b0;
    end
    // halves of six and seven cycles, 65 ns mean
    task half(input integer n);
        repeat (n) @(negedge clk_sys);
    endtask
    task sel;
        cs_n = 1'b0;
    endtask
    // sck pulses while deselected
    task idle;
        repeat (24) begin
            half(6);
            sck = 1'b1;
            half(7);
            sck = 1'b0;
        end
    endtask
    // one select of nb clocks; rd holds rise samples then the tail level
    task xfer(input [15:0] word, input integer nb, output reg [24:0] rd);
        begin
            cs_n = 1'b0;
            w = 0;
            while (serial_out !== 1'b0 && w < 4000) begin
                half(1);
                w = w + 1;
            end
            for (i = 0; i < nb; i = i + 1) begin
                serial_in = (i < 16) ? word[15-i] : ~serial_in;
                half(6);
                sck = 1'b1;
                rd = {rd[23:0], serial_out};
                half(7);
                sck = 1'b0;
            end
            half(6);
            rd = {rd[23:0], serial_out};
            cs_n = 1'b1;
            serial_in = ~serial_in;
            half(8);
        end
    endtask
endmodule

// ### testbench.sv
`timescale 1ns/1ps
// =====================================================================
// bench top
module testbench;
    localparam [159:0] VALS = {20'h0ffff, 20'h10000, 20'h11170, 20'hfffff,
                               20'hf0000, 20'heffff, 20'h08000, 20'h00001};
    localparam [127:0] WRDS = {16'h8fff, 16'hb7ed, 16'ha35a, 16'hab80,
                               16'h1fff, 16'hba15, 16'ha0c0, 16'hbf9e};
    reg         clk_sys, rst, clk_en, conv_valid;
    reg  [19:0] conv_value;
    reg  [16:0] e_cfg;
    reg  [24:0] rd, r1;
    wire        cs_n, sck, serial_in, serial_out, serial_out_oe, so_pin;
    wire        conv_ready, conv_start, single_ended_sel, neg_is_common;
    wire        temp_sensor_pick, reject_sel_a, reject_sel_b, rate_double_sel;
    wire [3:0]  chan_pos, chan_neg;
    wire [2:0]  gain_code;
    wire [16:0] cfg_seen;
    integer     fail_count, num_checks, k, t;
    assign cfg_seen = {single_ended_sel, chan_pos, chan_neg, neg_is_common, temp_sensor_pick,
                       reject_sel_a, reject_sel_b, rate_double_sel, gain_code};
    assign so_pin = serial_out_oe ? serial_out : 1'bz;

    asfc_top dut (
        .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .cs_n(cs_n), .sck(sck),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .conv_value(conv_value), .conv_valid(conv_valid), .conv_ready(conv_ready),
        .conv_start(conv_start), .single_ended_sel(single_ended_sel), .chan_pos(chan_pos),
        .chan_neg(chan_neg), .neg_is_common(neg_is_common),
        .temp_sensor_pick(temp_sensor_pick), .reject_sel_a(reject_sel_a),
        .reject_sel_b(reject_sel_b), .rate_double_sel(rate_double_sel), .gain_code(gain_code)
    );
    asfc_host host (.clk_sys(clk_sys), .cs_n(cs_n), .sck(sck), .serial_in(serial_in),
                    .serial_out(so_pin));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task chk(input [63:0] nm, input [24:0] seen, input [24:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("[ERR] %0s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d errors %0d", num_checks, fail_count);
            if (fail_count == 0 && num_checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    // expected 18-bit field
    function [17:0] fexp(input [19:0] v);
        if ($signed(v) >= 20'sd65536)
            fexp = 18'h30000;
        else if ($signed(v) < -20'sd65536)
            fexp = 18'h0ffff;
        else
            fexp = {~v[16], v[16:0]};
    endfunction
    task push(input [19:0] v);
        begin
            @(negedge clk_sys);
            conv_value = v;
            conv_valid = 1'b1;
            t = 0;
            while (conv_ready !== 1'b1 && t < 4000) begin
                @(negedge clk_sys);
                t = t + 1;
            end
            chk("push", {24'h0, conv_ready}, 25'h1);
            @(negedge clk_sys);
            conv_valid = 1'b0;
            conv_value = ~v;
        end
    endtask
    // full frame, then configuration as the word implies
    task frame(input [15:0] w, input [17:0] f);
        begin
            host.xfer(w, 24, rd);
            chk("frame", rd, {2'b00, f, 5'h01});
            if (w[15:13] == 3'h5) begin
                e_cfg[16:7] = {w[12], w[10:8], w[11], w[12] ? 4'h0 : {w[10:8], ~w[11]}, w[12]};
                if (w[7])
                    e_cfg[6:0] = w[6:0];
            end
            chk("config", {8'h0, cfg_seen}, {8'h0, e_cfg});
        end
    endtask

    initial begin
        #500000;
        fail_count = fail_count + 1;
        stop_test;
    end

    initial begin
        {rst, clk_en, conv_valid, conv_value, fail_count, num_checks} = 0;
        rst = 1'b1;
        clk_en = 1'b1;
        e_cfg = 17'h00100;
        repeat (3) @(negedge clk_sys);
        chk("start", {24'h0, conv_start}, 25'h1);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk("config", {8'h0, cfg_seen}, {8'h0, e_cfg});
        host.idle;
        chk("oe", {24'h0, serial_out_oe}, 25'h0);
        host.sel;
        repeat (8) @(negedge clk_sys);
        chk("busy", {23'h0, serial_out_oe, serial_out}, 25'h3);
        push(20'h00000);
        repeat (6) @(negedge clk_sys);
        chk("done", {23'h0, serial_out_oe, serial_out}, 25'h2);
        frame(16'h0000, fexp(20'h00000));
        for (k = 0; k < 8; k = k + 1) begin
            push(VALS[20*k +: 20]);
            frame(WRDS[16*k +: 16], fexp(VALS[20*k +: 20]));
        end
        push(20'h00000);
        push(20'h00000);
        repeat (3) @(negedge clk_sys);
        chk("ready", {24'h0, conv_ready}, 25'h0);
        host.xfer(16'h0000, 24, r1);
        host.xfer(16'h0000, 24, rd);
        chk("zero", {7'h0, r1[22:5] ^ rd[22:5]}, 25'h20000);
        push(20'h01234);
        host.xfer(16'hbfff, 8, rd);
        chk("abort", {8'h0, cfg_seen}, {8'h0, e_cfg});
        push(20'h00777);
        frame(16'h8000, fexp(20'h00777));
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        e_cfg = 17'h00100;
        repeat (4) @(negedge clk_sys);
        chk("config", {8'h0, cfg_seen}, {8'h0, e_cfg});
        stop_test;
    end
endmodule
